// file: verification/sepi_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sepi_core_properties #(
  parameter int PROG_CYCLES  = 50,
  parameter int PWRUP_CYCLES = 20
) (
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic       cs_n_in,
  input wire logic       sck_in,
  input wire logic       si_in,
  input wire logic       wp_n_in,
  input wire logic       hold_n_in,
  input wire logic       so_out,
  input wire logic       so_oe_out,
  input wire logic [7:0] opcode_out,
  input wire logic [8:0] addr_out,
  input wire logic       cmd_valid_out,
  input wire logic       busy_out,
  input wire logic       ready_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // Uptime saturates so a long run cannot wrap it
  logic [19:0] up_reg;
  logic [19:0] bsy_reg;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      up_reg <= 20'h0;
      bsy_reg <= 20'h0;
    end else begin
      up_reg <= (up_reg == 20'hfffff) ? up_reg : up_reg + 20'h1;
      bsy_reg <= busy_out ? bsy_reg + 20'h1 : 20'h0;
    end
  end
  AST_OE_CS: assert property (cs_n_in [*6] |-> !so_oe_out)
    else $error("output driven while deselected");
  AST_OE_HOLD: assert property (!hold_n_in [*6] |-> !so_oe_out)
    else $error("output driven while paused");
  AST_OE_RISE: assert property ($rose(so_oe_out) |-> !cs_n_in && hold_n_in)
    else $error("output enabled without selection");
  AST_SO_EDGE: assert property (so_oe_out && $past(so_oe_out) && $changed(so_out)
    |-> !($past(sck_in, 2) && $past(sck_in, 3) && $past(sck_in, 4) && $past(sck_in, 5)))
    else $error("output changed late in clock high phase");
  AST_CMD_PULSE: assert property (cmd_valid_out |=> !cmd_valid_out)
    else $error("command strobe longer than one cycle");
  AST_CMD_SEL: assert property (cmd_valid_out |-> !cs_n_in)
    else $error("command strobe outside a frame");
  AST_BUSY_MAX: assert property (bsy_reg <= PROG_CYCLES)
    else $error("program cycle too long");
  AST_BUSY_START: assert property ($rose(busy_out) |-> $past(cs_n_in, 2) && $past(wp_n_in, 2))
    else $error("program cycle started wrongly");
  AST_READY: assert property (ready_out |-> !busy_out && (up_reg + 20'd2 >= PWRUP_CYCLES))
    else $error("ready while busy or before power-up wait");
  AST_BUSY_END: assert property ($fell(busy_out) |-> ##[0:2] ready_out)
    else $error("not ready after program cycle");
endmodule // sepi_core_properties
bind sepi_core sepi_core_properties #(.PROG_CYCLES(PROG_CYCLES), .PWRUP_CYCLES(PWRUP_CYCLES)) u_props (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .cs_n_in(cs_n_in), .sck_in(sck_in),
  .si_in(si_in), .wp_n_in(wp_n_in), .hold_n_in(hold_n_in), .so_out(so_out),
  .so_oe_out(so_oe_out), .opcode_out(opcode_out), .addr_out(addr_out),
  .cmd_valid_out(cmd_valid_out), .busy_out(busy_out), .ready_out(ready_out));
`default_nettype wire

// file: verification/sepi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sepi_host_model #(
  parameter int HALF = 4
) (
  input  wire logic core_clk_in,
  input  wire logic so_out,
  input  wire logic so_oe_out,
  output var  logic cs_n_out,
  output var  logic sck_out,
  output var  logic si_out,
  output var  logic hold_n_out
);
  logic idle_sck;
  logic so_seen;
  logic oe_in_hold;
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    hold_n_out = 1'b1;
    idle_sck = 1'b0;
    so_seen = 1'b0;
    oe_in_hold = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // The serial clock takes the idle level of the mode before chip select falls
  task automatic start(input logic mode11);
    wait_cyc(1);
    sck_out = mode11;
    idle_sck = mode11;
    wait_cyc(HALF);
    cs_n_out = 1'b0;
    wait_cyc(HALF);
  endtask
  task automatic stop();
    wait_cyc(HALF);
    sck_out = idle_sck;
    wait_cyc(HALF);
    cs_n_out = 1'b1;
    wait_cyc(2 * HALF);
  endtask
  // Stray clock and data edges inside the pause must be ignored
  task automatic pause();
    hold_n_out = 1'b0;
    wait_cyc(HALF);
    sck_out = 1'b1;
    si_out = ~si_out;
    wait_cyc(HALF);
    sck_out = 1'b0;
    si_out = ~si_out;
    wait_cyc(HALF);
    oe_in_hold = so_oe_out;
    hold_n_out = 1'b1;
    wait_cyc(HALF);
  endtask
  // A released output reads as the inverse of the last bit seen
  task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_out = 1'b0;
      si_out = tx[i];
      wait_cyc(HALF);
      if (i == hold_at) pause();
      sck_out = 1'b1;
      wait_cyc(HALF);
      so_seen = so_oe_out ? so_out : ~so_seen;
      rx[i] = so_seen;
    end
  endtask
endmodule // sepi_host_model
`default_nettype wire

// file: verification/test_spi_eeprom_pin_interface.sv
`timescale 1ns/1ps
`default_nettype none
`include "sepi_regs.vh"
module test_spi_eeprom_pin_interface;
  localparam int PROG = 400;
  localparam int PWR  = 20;
  localparam logic [7:0] status_read_cmd = `SEPI_OP_STATUS_READ_CMD;
  logic       core_clk_in;
  logic       reset_in;
  logic       wp_n_in;
  wire logic  cs_n;
  wire logic  sck;
  wire logic  si;
  wire logic  hold_n;
  logic       so;
  logic       so_oe;
  logic [7:0] opcode_out;
  logic [8:0] addr_out;
  logic       cmd_valid_out;
  logic       busy_out;
  logic       ready_out;
  logic [7:0] s;
  logic [7:0] r;
  int         error_cnt;
  int         n_tests;
  sepi_core #(.PROG_CYCLES(PROG), .PWRUP_CYCLES(PWR)) dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .wp_n_in(wp_n_in), .hold_n_in(hold_n), .so_out(so), .so_oe_out(so_oe),
    .opcode_out(opcode_out), .addr_out(addr_out), .cmd_valid_out(cmd_valid_out),
    .busy_out(busy_out), .ready_out(ready_out));
  sepi_host_model host (
    .core_clk_in(core_clk_in), .so_out(so), .so_oe_out(so_oe), .cs_n_out(cs_n),
    .sck_out(sck), .si_out(si), .hold_n_out(hold_n));
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h0, exp}, {7'h0, got});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic op1(input logic m, input logic [7:0] op);
    host.start(m);
    host.xfer(op, 9, r);
    host.stop();
  endtask
  task automatic rd_st(input logic m, input int h);
    host.start(m);
    host.xfer(status_read_cmd, 9, r);
    host.xfer(8'h00, h, s);
    host.stop();
  endtask
  task automatic wr_sr(input logic [7:0] d, input logic abort);
    op1(0, `SEPI_OP_WREN);
    host.start(0);
    host.xfer(`SEPI_OP_WRSR, 9, r);
    host.xfer(d, 9, r);
    if (abort) wp_n_in = 1'b0;
    host.stop();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 2 * PROG) begin
      @(negedge core_clk_in);
      n++;
    end
    chk1("busy end", 1'b0, busy_out);
  endtask
  task automatic t_powerup();
    int n;
    n = 0;
    chk1("oe idle", 1'b0, so_oe);
    chk1("ready early", 1'b0, ready_out);
    while (ready_out !== 1'b1 && n < PWR + 20) begin
      @(negedge core_clk_in);
      n++;
    end
    chk1("ready", 1'b1, ready_out);
    $display("test powerup done");
  endtask
  task automatic t_cmds();
    logic [7:0] bad [3] = '{8'h86, 8'h0e, 8'h07};
    op1(0, `SEPI_OP_WREN);
    chk8("opcode", `SEPI_OP_WREN, opcode_out);
    rd_st(0, 9);
    chk8("status enabled", 8'hf2, s);
    op1(1, `SEPI_OP_WRDI);
    foreach (bad[i]) op1(0, bad[i]);
    rd_st(1, 9);
    chk8("status mode 1,1", 8'hf0, s);
    $display("test commands done");
  endtask
  task automatic t_hold();
    host.start(0);
    host.xfer(`SEPI_OP_WREN, 3, r);
    host.stop();
    rd_st(0, 5);
    chk8("status after hold", 8'hf2, s);
    chk1("oe in hold", 1'b0, host.oe_in_hold);
    $display("test hold done");
  endtask
  task automatic t_wp();
    wp_n_in = 1'b0;
    wr_sr(8'h0c, 1'b0);
    repeat (20) @(negedge core_clk_in);
    chk1("busy wp low", 1'b0, busy_out);
    rd_st(0, 9);
    wp_n_in = 1'b1;
    chk8("bp kept", 8'h00, s & 8'h0c);
    wr_sr(8'h0c, 1'b0);
    rd_st(0, 9);
    chk1("busy bit", 1'b1, s[0]);
    op1(0, `SEPI_OP_WREN);
    wait_idle();
    rd_st(0, 9);
    chk8("status after write", 8'hfc, s);
    $display("test protect done");
  endtask
  task automatic t_abort();
    wr_sr(8'h00, 1'b1);
    wp_n_in = 1'b1;
    repeat (20) @(negedge core_clk_in);
    chk1("busy abort", 1'b0, busy_out);
    rd_st(0, 9);
    chk8("bp after abort", 8'h0c, s & 8'h0c);
    wr_sr(8'h00, 1'b0);
    wp_n_in = 1'b0;
    wait_idle();
    wp_n_in = 1'b1;
    rd_st(0, 9);
    chk8("status late wp", 8'hf0, s);
    $display("test abort done");
  endtask
  task automatic t_array();
    // Quarter protection covers the top of the array, so this write must not start
    wr_sr(8'h04, 1'b0);
    wait_idle();
    op1(0, `SEPI_OP_WREN);
    host.start(0);
    host.xfer(`SEPI_OP_WRITE | 8'h08, 9, r);
    host.xfer(8'ha5, 9, r);
    host.xfer(8'h5a, 9, r);
    host.stop();
    chk1("busy protected", 1'b0, busy_out);
    wr_sr(8'h00, 1'b0);
    wait_idle();
    op1(0, `SEPI_OP_WREN);
    host.start(0);
    host.xfer(`SEPI_OP_WRITE | 8'h08, 9, r);
    host.xfer(8'ha5, 9, r);
    host.xfer(8'h3c, 9, r);
    host.xfer(8'hc3, 9, r);
    host.stop();
    wait_idle();
    host.start(1);
    host.xfer(`SEPI_OP_READ | 8'h08, 9, r);
    host.xfer(8'ha5, 9, r);
    host.xfer(8'h00, 9, s);
    chk8("array byte 0", 8'h3c, s);
    host.xfer(8'h00, 9, s);
    chk8("array byte 1", 8'hc3, s);
    host.stop();
    chk8("read address low", 8'ha7, addr_out[7:0]);
    chk1("read address top", 1'b1, addr_out[8]);
    $display("test array done");
  endtask
  initial begin
    error_cnt = 0;
    n_tests = 0;
    wp_n_in = 1'b1;
    reset_in = 1'b1;
    repeat (5) @(negedge core_clk_in);
    reset_in = 1'b0;
    t_powerup();
    t_cmds();
    t_hold();
    t_wp();
    t_abort();
    t_array();
    end_of_test();
  end
  // Whole run needs well under 20000 cycles
  initial begin
    #1000000;
    error_cnt++;
    end_of_test();
  end
endmodule // test_spi_eeprom_pin_interface
`default_nettype wire

// file: verilog/sepi_core.v
// Functional notes
// - Serial input is sampled on each rising serial clock edge while selected, in both clock modes.
// - Serial output changes only on falling serial clock edges while sending.
// - The serial output is high impedance whenever chip select is high.
// - Chip select high means standby, except that a running program cycle carries on to the end.
// - Writes to array and status are allowed only while write protect is high.
// - Hold low suspends the transfer, hold high resumes it from the same bit.
// - The program cycle started by chip select rising after a valid write finishes within 5 ms.
// - All host communication is timed from the host serial clock alone; the core finds its edges by sampling the pins on core_clk_in.
// - Only the six defined 8-bit instructions are acted on; other codes are ignored.
// - The busy status bit reads 1 throughout a program cycle and 0 when ready.
// - During a program cycle every instruction except status read is ignored.
// - Write protect falling while selected aborts a pending status write; after programming starts it has no effect.
`timescale 1ns/1ps
`default_nettype none
`include "sepi_regs.vh"
module sepi_core #(
  parameter PROG_CYCLES  = `SEPI_PROG_CYCLES,
  parameter PWRUP_CYCLES = `SEPI_PWRUP_CYCLES
) (
  input  wire       core_clk_in,
  input  wire       reset_in,
  input  wire       cs_n_in,
  input  wire       sck_in,
  input  wire       si_in,
  input  wire       wp_n_in,
  input  wire       hold_n_in,
  output reg        so_out,
  output reg        so_oe_out,
  output reg  [7:0] opcode_out,
  output reg  [8:0] addr_out,
  output reg        cmd_valid_out,
  output reg        busy_out,
  output reg        ready_out
);
  localparam ST_IDLE = 3'd0;
  localparam ST_OP   = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_WDAT = 3'd3;
  localparam ST_RDAT = 3'd4;
  localparam ST_SDAT = 3'd5;
  localparam ST_SKIP = 3'd6;

  function [2:0] op_class;
    input [7:0] op;
    begin
      if (op == `SEPI_OP_WREN)                           op_class = 3'd1;
      else if (op == `SEPI_OP_WRDI)                      op_class = 3'd2;
      else if (op == `SEPI_OP_STATUS_READ_CMD)           op_class = 3'd3;
      else if (op == `SEPI_OP_WRSR)                      op_class = 3'd4;
      else if ((op & `SEPI_OP_A8_MASK) == `SEPI_OP_READ)  op_class = 3'd5;
      else if ((op & `SEPI_OP_A8_MASK) == `SEPI_OP_WRITE) op_class = 3'd6;
      else                                               op_class = 3'd0;
    end
  endfunction

  // Two-flop synchronisers; stage one feeds only stage two
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  reg       sck_d_reg;
  reg       cs_d_reg;
  reg       wp_d_reg;
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_reg <= 5'h1d;
      sync2_reg <= 5'h1d;
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
      wp_d_reg  <= 1'b1;
    end else begin
      sync1_reg <= {hold_n_in, wp_n_in, si_in, sck_in, cs_n_in};
      sync2_reg <= sync1_reg;
      sck_d_reg <= sync2_reg[1];
      cs_d_reg  <= sync2_reg[0];
      wp_d_reg  <= sync2_reg[3];
    end
  end
  wire cs_n   = sync2_reg[0];
  wire sck    = sync2_reg[1];
  wire si     = sync2_reg[2];
  wire wp_n   = sync2_reg[3];
  wire hold_n = sync2_reg[4];
  wire active = ~cs_n & hold_n;
  wire sck_rise = active & sck & ~sck_d_reg;
  wire sck_fall = active & ~sck & sck_d_reg;
  wire cs_rise  = cs_n & ~cs_d_reg;
  wire cs_fall  = ~cs_n & cs_d_reg;

  reg [2:0]  state_reg;
  reg [2:0]  cls_reg;
  reg [7:0]  shift_reg;
  reg [2:0]  bit_reg;
  reg [7:0]  tx_reg;
  reg        wel_reg;
  reg [1:0]  bp_reg;
  reg [1:0]  bp_pend_reg;
  reg        sr_pend_reg;
  reg        arr_pend_reg;
  reg [8:0]  page_base_reg;
  reg [3:0]  page_cnt_reg;
  reg [22:0] prog_cnt_reg;
  reg [15:0] pwr_cnt_reg;
  reg        prog_reg;
  reg        rd_next_reg;
  reg        rd_load_reg;

  wire [7:0] status = {`SEPI_SR_FIXED, bp_reg, wel_reg, prog_reg};
  wire [7:0] shift_next = {shift_reg[6:0], si};
  wire       byte_done = sck_rise && (bit_reg == 3'd7);

  // Block protection: protected region from the top of the array
  function is_protected;
    input [1:0] bp;
    input [8:0] a;
    begin
      case (bp)
        2'd1:    is_protected = (a[8:7] == 2'b11);
        2'd2:    is_protected = a[8];
        2'd3:    is_protected = 1'b1;
        default: is_protected = 1'b0;
      endcase
    end
  endfunction

  // Page data buffer in the FIFO; drained into the array while programming
  wire       fifo_in_ready;
  wire [7:0] fifo_rd_data;
  wire       fifo_rd_valid;
  wire       drain = prog_reg & arr_pend_reg;
  wire [7:0] mem_rd_data;
  reg  [8:0] wr_addr_reg;
  wire       fifo_push = byte_done && (state_reg == ST_WDAT) && (page_cnt_reg != 4'hf || 1'b1);
  sepi_fifo #(
    .WIDTH(8),
    .DEPTH(`SEPI_FIFO_DEPTH),
    .AW   (`SEPI_FIFO_AW)
  ) u_fifo (
    .clk_in      (core_clk_in),
    .reset_in    (reset_in),
    .wr_data_in  (shift_next),
    .wr_valid_in (fifo_push & fifo_in_ready),
    .wr_ready_out(fifo_in_ready),
    .rd_data_out (fifo_rd_data),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in (drain),
    .flush_in    (cs_fall & ~prog_reg)
  );
  sepi_mem #(
    .AW(`SEPI_MEM_AW)
  ) u_mem (
    .clk_in     (core_clk_in),
    .wr_en_in   (drain & fifo_rd_valid),
    .wr_addr_in (wr_addr_reg),
    .wr_data_in (fifo_rd_data),
    .rd_addr_in (addr_out),
    .rd_data_out(mem_rd_data)
  );

  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg     <= ST_IDLE;
      cls_reg       <= 3'd0;
      shift_reg     <= 8'h00;
      bit_reg       <= 3'd0;
      tx_reg        <= 8'h00;
      wel_reg       <= 1'b0;
      bp_reg        <= 2'b00;
      bp_pend_reg   <= 2'b00;
      sr_pend_reg   <= 1'b0;
      arr_pend_reg  <= 1'b0;
      page_base_reg <= 9'h000;
      page_cnt_reg  <= 4'h0;
      prog_cnt_reg  <= 23'h000000;
      pwr_cnt_reg   <= 16'h0000;
      prog_reg      <= 1'b0;
      rd_next_reg   <= 1'b0;
      rd_load_reg   <= 1'b0;
      wr_addr_reg   <= 9'h000;
      so_out        <= 1'b0;
      so_oe_out     <= 1'b0;
      opcode_out    <= 8'h00;
      addr_out      <= 9'h000;
      cmd_valid_out <= 1'b0;
      busy_out      <= 1'b0;
      ready_out     <= 1'b0;
    end else begin
      cmd_valid_out <= 1'b0;
      busy_out      <= prog_reg;
      // Power-up guard only gates the ready flag; the host owns the wait
      if (pwr_cnt_reg != PWRUP_CYCLES[15:0]) begin
        pwr_cnt_reg <= pwr_cnt_reg + 16'h0001;
      end
      ready_out <= (pwr_cnt_reg == PWRUP_CYCLES[15:0]) & ~prog_reg;
      so_oe_out <= active & ((state_reg == ST_RDAT) | (state_reg == ST_SDAT));
      // Self-timed programming continues regardless of chip select
      if (prog_reg) begin
        if (fifo_rd_valid) begin
          wr_addr_reg <= page_base_reg | {5'h00, wr_addr_reg[3:0] + 4'h1};
        end
        if (prog_cnt_reg == PROG_CYCLES[22:0] - 23'h000001) begin
          prog_reg     <= 1'b0;
          arr_pend_reg <= 1'b0;
          wel_reg      <= 1'b0;
          if (sr_pend_reg) begin
            bp_reg <= bp_pend_reg;
          end
          sr_pend_reg <= 1'b0;
        end else begin
          prog_cnt_reg <= prog_cnt_reg + 23'h000001;
        end
      end
      if (cs_fall) begin
        state_reg   <= ST_OP;
        bit_reg     <= 3'd0;
        if (~prog_reg) begin
          sr_pend_reg  <= 1'b0;
          arr_pend_reg <= 1'b0;
        end
      end else if (cs_rise) begin
        state_reg <= ST_IDLE;
        if (cls_reg == 3'd1) begin
          wel_reg <= 1'b1;
        end else if (cls_reg == 3'd2) begin
          wel_reg <= 1'b0;
        end
        if (~prog_reg && (sr_pend_reg || arr_pend_reg) && bit_reg == 3'd0) begin
          prog_reg     <= 1'b1;
          prog_cnt_reg <= 23'h000000;
          wr_addr_reg  <= addr_out;
        end
        cls_reg <= 3'd0;
      end else if (~cs_n && wp_d_reg && ~wp_n && ~prog_reg) begin
        sr_pend_reg <= 1'b0;
      end
      if (sck_fall) begin
        so_out <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
      if (sck_rise && ~cs_fall) begin
        shift_reg <= shift_next;
        bit_reg   <= bit_reg + 3'd1;
      end
      // Array data lags the new address by one clock, so load one clock later
      rd_load_reg <= rd_next_reg;
      if (rd_load_reg) begin
        tx_reg <= mem_rd_data;
      end
      if (rd_next_reg) begin
        rd_next_reg <= 1'b0;
      end
      if (byte_done && ~cs_fall) begin
        case (state_reg)
          ST_OP: begin
            opcode_out    <= shift_next;
            cmd_valid_out <= 1'b1;
            cls_reg       <= 3'd0;
            if (prog_reg && op_class(shift_next) != 3'd3) begin
              state_reg <= ST_SKIP;
            end else begin
              case (op_class(shift_next))
                3'd1, 3'd2: begin
                  cls_reg   <= op_class(shift_next);
                  state_reg <= ST_SKIP;
                end
                3'd3: begin
                  tx_reg    <= status;
                  state_reg <= ST_SDAT;
                end
                3'd4: begin
                  cls_reg   <= 3'd4;
                  state_reg <= ST_WDAT;
                end
                3'd5, 3'd6: begin
                  cls_reg     <= op_class(shift_next);
                  addr_out[8] <= shift_next[3];
                  state_reg   <= ST_ADDR;
                end
                default: state_reg <= ST_SKIP;
              endcase
            end
          end
          ST_ADDR: begin
            addr_out[7:0] <= shift_next;
            page_base_reg <= {addr_out[8], shift_next[7:4], 4'h0};
            page_cnt_reg  <= 4'h0;
            if (cls_reg == 3'd5) begin
              state_reg   <= ST_RDAT;
              rd_next_reg <= 1'b1;
            end else begin
              state_reg <= ST_WDAT;
            end
          end
          ST_WDAT: begin
            if (cls_reg == 3'd4) begin
              bp_pend_reg <= shift_next[`SEPI_SR_BP1_BIT:`SEPI_SR_BP0_BIT];
              sr_pend_reg <= wel_reg & wp_n;
              state_reg   <= ST_SKIP;
            end else begin
              arr_pend_reg <= wel_reg & wp_n & ~is_protected(bp_reg, addr_out);
              page_cnt_reg <= page_cnt_reg + 4'h1;
            end
          end
          ST_RDAT: begin
            addr_out    <= addr_out + 9'h001;
            rd_next_reg <= 1'b1;
          end
          ST_SDAT: tx_reg <= status;
          ST_SKIP: state_reg <= ST_SKIP;
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // sepi_core
`default_nettype wire

// file: verilog/sepi_fifo.v
`timescale 1ns/1ps
`default_nettype none
module sepi_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_in,
  input  wire             reset_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output reg  [WIDTH-1:0] rd_data_out,
  output reg              rd_valid_out,
  input  wire             rd_ready_in,
  input  wire             flush_in
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire            full;
  wire            empty;
  wire            pop;
  assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign wr_ready_out = ~full;
  // Output register refills whenever it is free or being taken
  assign pop = ~empty && (~rd_valid_out || rd_ready_in);
  always @(posedge clk_in) begin
    if (wr_valid_in && ~full) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= wr_data_in;
    end
  end
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_reg   <= {(AW+1){1'b0}};
      rd_ptr_reg   <= {(AW+1){1'b0}};
      rd_data_out  <= {WIDTH{1'b0}};
      rd_valid_out <= 1'b0;
    end else if (flush_in) begin
      wr_ptr_reg   <= {(AW+1){1'b0}};
      rd_ptr_reg   <= {(AW+1){1'b0}};
      rd_valid_out <= 1'b0;
    end else begin
      if (wr_valid_in && ~full) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_data_out  <= mem_reg[rd_ptr_reg[AW-1:0]];
        rd_valid_out <= 1'b1;
        rd_ptr_reg   <= rd_ptr_reg + 1'b1;
      end else if (rd_ready_in) begin
        rd_valid_out <= 1'b0;
      end
    end
  end
endmodule // sepi_fifo
`default_nettype wire

// file: verilog/sepi_mem.v
`timescale 1ns/1ps
`default_nettype none
module sepi_mem #(
  parameter AW = 9
) (
  input  wire          clk_in,
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [7:0]    wr_data_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [7:0]    rd_data_out
);
  reg [7:0] array_reg [0:(1<<AW)-1];
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      array_reg[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= array_reg[rd_addr_in];
  end
endmodule // sepi_mem
`default_nettype wire

// file: verilog/sepi_regs.vh
`ifndef SEPI_REGS_VH
`define SEPI_REGS_VH

`define SEPI_CLK_PERIOD_NS      25
`define SEPI_PROG_TIME_NS       5000000
`define SEPI_PROG_CYCLES        (`SEPI_PROG_TIME_NS / `SEPI_CLK_PERIOD_NS)
`define SEPI_PWRUP_TIME_NS      1000000
`define SEPI_PWRUP_CYCLES       ((`SEPI_PWRUP_TIME_NS + `SEPI_CLK_PERIOD_NS - 1) / `SEPI_CLK_PERIOD_NS)

`define SEPI_OP_WREN            8'h06
`define SEPI_OP_WRDI            8'h04
`define SEPI_OP_STATUS_READ_CMD 8'h05
`define SEPI_OP_WRSR            8'h01
`define SEPI_OP_READ            8'h03
`define SEPI_OP_WRITE           8'h02
`define SEPI_OP_A8_MASK         8'hf7

`define SEPI_SR_RDY_BIT         0
`define SEPI_SR_WEL_BIT         1
`define SEPI_SR_BP0_BIT         2
`define SEPI_SR_BP1_BIT         3
`define SEPI_SR_FIXED           4'hf

`define SEPI_FIFO_DEPTH         32
`define SEPI_FIFO_AW            5
`define SEPI_PAGE_BYTES         16
`define SEPI_MEM_WORDS          512
`define SEPI_MEM_AW             9

`endif
